/* logic/dcl_pkg.sv */
// Purpose: constants for the defect correlation logic
// Assumes: one frame-rate clock, inputs synchronous to it
// Notes: no register bus; options are plain ports
package dcl_pkg;
  localparam logic [0:0] DCL_OPT_RESET = 1'h0;
  localparam logic [0:0] DCL_OUT_RESET = 1'h0;
  localparam int         DCL_TRACE_W   = 8;
  localparam int         DCL_PORTS     = 4;
  localparam logic [7:0] DCL_UNEQ_LABEL = 8'h00;
  typedef enum logic {
    DCL_OPT_IDLE,
    DCL_OPT_LOADED
  } dcl_opt_state_t;
endpackage

/* logic/dcl_correlate.sv */
// Purpose: consequent action requests and fault cause correlation
// Assumes: defect inputs synchronous to clk, frameTick once per frame
// Notes: requests and causes change only on frameTick, options on optLoad; syncClear clears all outputs
`timescale 1ns/10ps
`default_nettype none
module dcl_correlate #(
  parameter int TRACE_W = dcl_pkg::DCL_TRACE_W,
  parameter int PORTS   = dcl_pkg::DCL_PORTS,
  parameter bit HAS_ONES_DETECTOR = 1'b1
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               syncClear,
  input  wire logic               frameTick,
  input  wire logic               optLoad,
  input  wire logic               serverFailReportIn,
  input  wire logic               farDefectReportIn,
  input  wire logic               allOnesReportIn,
  input  wire logic               supervisionActive,
  input  wire logic               labelMismatchDefect,
  input  wire logic               allOnesDefect,
  input  wire logic               alignmentLostDefect,
  input  wire logic               trailFailIn,
  input  wire logic               serverFailIn,
  input  wire logic               noPayloadDefect,
  input  wire logic               inputLostDefect,
  input  wire logic               traceMismatchDefect,
  input  wire logic               signalWorsenedDefect,
  input  wire logic               farDefectIndication,
  input  wire logic [TRACE_W-1:0] acceptedTraceId,
  input  wire logic               unitDefect,
  input  wire logic [PORTS-1:0]   outputConnected,
  input  wire logic [PORTS-1:0]   slotInstalled,
  output logic                    serverFailRequest,
  output logic                    trailFailRequest,
  output logic                    supTrailFailRequest,
  output logic                    trailWorsenedRequest,
  output logic                    serverWorsenedRequest,
  output logic                    unitFaultSignal,
  output logic [PORTS-1:0]        insertUnequipped,
  output logic                    serverFailReportOpt,
  output logic                    farDefectReportOpt,
  output logic                    allOnesReportOpt,
  output logic                    noPayloadCause,
  output logic                    traceMismatchCause,
  output logic                    signalWorsenedCause,
  output logic                    farDefectCause,
  output logic                    serverFailCause,
  output logic                    inputLostCause,
  output logic                    allOnesCause,
  output logic                    supNoPayloadCause,
  output logic                    supTraceMismatchCause,
  output logic                    supSignalWorsenedCause,
  output logic                    supFarDefectCause,
  output logic                    supServerFailCause,
  output logic                    labelMismatchCause,
  output logic                    adaptAllOnesCause,
  output logic                    alignmentLostCause
);

  // without a local ones detector the upstream trail fail stands in
  wire logic onesTerm      = HAS_ONES_DETECTOR ? allOnesDefect : trailFailIn;
  // section termination sees server faults via the ones defect, or via serverFailIn without a ones detector
  wire logic sinkOnesTerm  = HAS_ONES_DETECTOR ? allOnesDefect : serverFailIn;
  wire logic traceZero     = (acceptedTraceId == '0);
  wire logic unequipSeen   = noPayloadDefect & traceZero;

  wire logic next_ssf      = labelMismatchDefect | onesTerm | alignmentLostDefect;
  wire logic next_tsf      = sinkOnesTerm | noPayloadDefect | inputLostDefect | traceMismatchDefect;
  wire logic next_stsf     = serverFailIn | ~noPayloadDefect | traceMismatchDefect;
  wire logic next_tsd      = signalWorsenedDefect;
  wire logic [PORTS-1:0] next_uneq = ~outputConnected | ~slotInstalled;

  // correlation relies on detectors clearing their defects under fail
  wire logic watchOn = supervisionActive;
  wire logic next_no_payload_cause    = watchOn & noPayloadDefect;
  wire logic next_trace_mismatch_cause     = watchOn & ~noPayloadDefect & traceMismatchDefect;
  wire logic next_signal_worsened_cause     = watchOn & ~traceMismatchDefect & signalWorsenedDefect;
  wire logic next_far_defect_cause     = watchOn & ~noPayloadDefect & ~traceMismatchDefect
                             & farDefectIndication & farDefectReportOpt;
  wire logic next_server_fail_cause     = watchOn & (serverFailIn | allOnesDefect) & serverFailReportOpt;
  wire logic next_input_lost_cause     = watchOn & inputLostDefect;
  wire logic next_all_ones_cause     = watchOn & allOnesDefect & allOnesReportOpt;
  wire logic next_sUneq    = watchOn & traceMismatchDefect & unequipSeen;
  wire logic next_sTim     = watchOn & traceMismatchDefect & ~unequipSeen;
  wire logic next_sRdi     = watchOn & ~traceMismatchDefect & farDefectIndication
                             & farDefectReportOpt;
  wire logic next_sSsf     = watchOn & serverFailIn & serverFailReportOpt;
  wire logic next_label_mismatch_cause     = labelMismatchDefect & ~trailFailIn;
  wire logic next_aAis     = allOnesDefect & ~trailFailIn & ~labelMismatchDefect
                             & allOnesReportOpt;
  wire logic next_alignment_lost_cause     = alignmentLostDefect & ~allOnesDefect & ~labelMismatchDefect;

  // options keep false until management loads them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serverFailReportOpt <= dcl_pkg::DCL_OPT_RESET;
      farDefectReportOpt  <= dcl_pkg::DCL_OPT_RESET;
      allOnesReportOpt    <= dcl_pkg::DCL_OPT_RESET;
    end else if (syncClear) begin
      serverFailReportOpt <= dcl_pkg::DCL_OPT_RESET;
      farDefectReportOpt  <= dcl_pkg::DCL_OPT_RESET;
      allOnesReportOpt    <= dcl_pkg::DCL_OPT_RESET;
    end else if (optLoad) begin
      serverFailReportOpt <= serverFailReportIn;
      farDefectReportOpt  <= farDefectReportIn;
      allOnesReportOpt    <= allOnesReportIn;
    end
  end

  // requests: one update per frame keeps them aligned with the inserters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serverFailRequest     <= dcl_pkg::DCL_OUT_RESET;
      trailFailRequest      <= dcl_pkg::DCL_OUT_RESET;
      supTrailFailRequest   <= dcl_pkg::DCL_OUT_RESET;
      trailWorsenedRequest  <= dcl_pkg::DCL_OUT_RESET;
      serverWorsenedRequest <= dcl_pkg::DCL_OUT_RESET;
      unitFaultSignal       <= dcl_pkg::DCL_OUT_RESET;
      insertUnequipped      <= '0;
    end else if (syncClear) begin
      serverFailRequest     <= dcl_pkg::DCL_OUT_RESET;
      trailFailRequest      <= dcl_pkg::DCL_OUT_RESET;
      supTrailFailRequest   <= dcl_pkg::DCL_OUT_RESET;
      trailWorsenedRequest  <= dcl_pkg::DCL_OUT_RESET;
      serverWorsenedRequest <= dcl_pkg::DCL_OUT_RESET;
      unitFaultSignal       <= dcl_pkg::DCL_OUT_RESET;
      insertUnequipped      <= '0;
    end else if (frameTick) begin
      serverFailRequest     <= next_ssf;
      trailFailRequest      <= next_tsf;
      supTrailFailRequest   <= next_stsf;
      trailWorsenedRequest  <= next_tsd;
      serverWorsenedRequest <= next_tsd;
      unitFaultSignal       <= unitDefect;
      insertUnequipped      <= next_uneq;
    end
  end

  // causes: set while true, cleared as soon as false, at frame rate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {noPayloadCause, traceMismatchCause, signalWorsenedCause, farDefectCause} <= '0;
      {serverFailCause, inputLostCause, allOnesCause} <= '0;
      {supNoPayloadCause, supTraceMismatchCause, supSignalWorsenedCause} <= '0;
      {supFarDefectCause, supServerFailCause} <= '0;
      {labelMismatchCause, adaptAllOnesCause, alignmentLostCause} <= '0;
    end else if (syncClear) begin
      {noPayloadCause, traceMismatchCause, signalWorsenedCause, farDefectCause} <= '0;
      {serverFailCause, inputLostCause, allOnesCause} <= '0;
      {supNoPayloadCause, supTraceMismatchCause, supSignalWorsenedCause} <= '0;
      {supFarDefectCause, supServerFailCause} <= '0;
      {labelMismatchCause, adaptAllOnesCause, alignmentLostCause} <= '0;
    end else if (frameTick) begin
      noPayloadCause         <= next_no_payload_cause;
      traceMismatchCause     <= next_trace_mismatch_cause;
      signalWorsenedCause    <= next_signal_worsened_cause;
      farDefectCause         <= next_far_defect_cause;
      serverFailCause        <= next_server_fail_cause;
      inputLostCause         <= next_input_lost_cause;
      allOnesCause           <= next_all_ones_cause;
      supNoPayloadCause      <= next_sUneq;
      supTraceMismatchCause  <= next_sTim;
      supSignalWorsenedCause <= next_signal_worsened_cause;
      supFarDefectCause      <= next_sRdi;
      supServerFailCause     <= next_sSsf;
      labelMismatchCause     <= next_label_mismatch_cause;
      adaptAllOnesCause      <= next_aAis;
      alignmentLostCause     <= next_alignment_lost_cause;
    end
  end

endmodule
`default_nettype wire

/* sim/dcl_neighbour.sv */
// Purpose: neighbouring detectors feeding the correlator
// Assumes: raw bits are random detector states
// Notes: detectors held clear while a fail is forwarded
`timescale 1ns/10ps
`default_nettype none
module dcl_neighbour (
  input  wire logic       serverFailIn,
  input  wire logic       trailFailIn,
  input  wire logic [3:0] raw,
  output logic      [3:0] detected
);
  assign detected = (serverFailIn | trailFailIn) ? 4'h0 : raw;
endmodule
`default_nettype wire

/* sim/dcl_correlate_assertions.sv */
// Purpose: port checks of requests and causes
// Assumes: ones detector present
// Notes: requests and causes move only on a frame tick or syncClear
`timescale 1ns/10ps
`default_nettype none
module dcl_correlate_assertions (
  input wire logic clk, sys_rst, syncClear, frameTick, supervisionActive, labelMismatchDefect, allOnesDefect,
  input wire logic alignmentLostDefect, serverFailIn, noPayloadDefect, inputLostDefect, traceMismatchDefect,
  input wire logic signalWorsenedDefect, serverFailRequest, trailFailRequest, supTrailFailRequest,
  input wire logic trailWorsenedRequest, serverWorsenedRequest, supSignalWorsenedCause, alignmentLostCause
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire sf = labelMismatchDefect | allOnesDefect | alignmentLostDefect;
  wire tf = allOnesDefect | noPayloadDefect | inputLostDefect | traceMismatchDefect;
  wire st = serverFailIn | ~noPayloadDefect | traceMismatchDefect;
  wire sw = supervisionActive & ~traceMismatchDefect & signalWorsenedDefect;
  wire al = alignmentLostDefect & ~allOnesDefect & ~labelMismatchDefect;
  sequence tick; frameTick && !syncClear; endsequence
  sequence idle; !frameTick && !syncClear; endsequence
  a_server_fail_req: assert property (tick |=> serverFailRequest == $past(sf)) else $error("bad server fail");
  a_trail_fail_req: assert property (tick |=> trailFailRequest == $past(tf)) else $error("bad trail fail");
  a_sup_trail_fail: assert property (tick |=> supTrailFailRequest == $past(st)) else $error("bad sup fail");
  a_worsened_copy: assert property (tick |=> trailWorsenedRequest == $past(signalWorsenedDefect)
    && serverWorsenedRequest == trailWorsenedRequest) else $error("bad degrade");
  a_sup_degrade: assert property (tick |=> supSignalWorsenedCause == $past(sw)) else $error("bad sup deg");
  a_align_cause: assert property (tick |=> alignmentLostCause == $past(al)) else $error("bad align");
  a_hold_idle: assert property (idle |=> $stable(trailFailRequest) && $stable(alignmentLostCause))
    else $error("moved off tick");
  a_sync_clear: assert property (syncClear |=> !serverFailRequest && !trailWorsenedRequest)
    else $error("not cleared");
endmodule
bind dcl_correlate dcl_correlate_assertions dcl_correlate_assertions_inst (.*);
`default_nettype wire

/* sim/dcl_correlate_test.sv */
// Purpose: random self-checking bench
// Assumes: default parameters
// Notes: trace forced to zero half the time to hit the unequipped signature
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module dcl_correlate_test;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [33:0] s = 34'h0;
  logic [31:0] r = 32'h2ee92d66;
  logic [31:0] r2;
  logic [9:0]  er, gr;
  logic [14:0] ec, gc;
  logic [2:0]  o, go;
  logic [3:0]  d;
  int          n_fail = 0, checks = 0, cyc = 0;
  wire mo = s[6], lb = s[7], on = s[8], al = s[9], tfi = s[10], sfi = s[11], il = s[16];
  wire np = d[0], tm = d[1], sw = d[2], fd = d[3], z = s[25:18] == 8'h00;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [9:0] req_f();
    return {lb | on | al, on | np | il | tm, sfi | ~np | tm, sw, sw, s[17], ~s[29:26] | ~s[33:30]};
  endfunction
  function automatic logic [14:0] cause_f();
    return {mo & np, mo & ~np & tm, mo & ~tm & sw, mo & ~np & ~tm & fd & o[1], mo & (sfi | on) & o[2], mo & il,
      mo & on & o[0], mo & tm & z & np, mo & tm & ~(np & z), mo & ~tm & sw, mo & ~tm & fd & o[1], mo & sfi & o[2],
      lb & ~tfi, on & ~tfi & ~lb & o[0], al & ~on & ~lb};
  endfunction
  dcl_neighbour dcl_neighbour_inst (.serverFailIn(sfi), .trailFailIn(tfi), .raw(s[15:12]), .detected(d));
  dcl_correlate dcl_correlate_inst (.clk(clk), .sys_rst(sys_rst), .syncClear(s[0]), .frameTick(s[1]),
    .optLoad(s[2]), .serverFailReportIn(s[5]), .farDefectReportIn(s[4]), .allOnesReportIn(s[3]),
    .supervisionActive(mo), .labelMismatchDefect(lb), .allOnesDefect(on), .alignmentLostDefect(al),
    .trailFailIn(tfi), .serverFailIn(sfi), .noPayloadDefect(np), .inputLostDefect(il), .traceMismatchDefect(tm),
    .signalWorsenedDefect(sw), .farDefectIndication(fd), .acceptedTraceId(s[25:18]), .unitDefect(s[17]),
    .outputConnected(s[29:26]), .slotInstalled(s[33:30]), .serverFailRequest(gr[9]), .trailFailRequest(gr[8]),
    .supTrailFailRequest(gr[7]), .trailWorsenedRequest(gr[6]), .serverWorsenedRequest(gr[5]),
    .unitFaultSignal(gr[4]), .insertUnequipped(gr[3:0]), .serverFailReportOpt(go[2]),
    .farDefectReportOpt(go[1]), .allOnesReportOpt(go[0]), .noPayloadCause(gc[14]), .traceMismatchCause(gc[13]),
    .signalWorsenedCause(gc[12]), .farDefectCause(gc[11]), .serverFailCause(gc[10]), .inputLostCause(gc[9]),
    .allOnesCause(gc[8]), .supNoPayloadCause(gc[7]), .supTraceMismatchCause(gc[6]), .supSignalWorsenedCause(gc[5]),
    .supFarDefectCause(gc[4]), .supServerFailCause(gc[3]), .labelMismatchCause(gc[2]), .adaptAllOnesCause(gc[1]),
    .alignmentLostCause(gc[0]));
  // options load after the tick, so a same-edge tick still sees the old ones
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst | s[0]) {er, ec, o} <= 28'h0;
    else begin
      if (s[1]) {er, ec} <= {req_f(), cause_f()};
      if (s[2]) o <= s[5:3];
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
    if (!sys_rst) begin
      r = xs(r);
      r2 = xs(r);
      s <= {r2[1:0], r[31:26], r2[12] ? 8'h00 : r[25:18], r[17:3], &r2[11:9], r2[8], &r2[7:2]};
      r = r2;
    end
  end
  always @(negedge clk) if (!sys_rst) begin
    `CHK("requests", er, gr)
    `CHK("options", o, go)
    `CHK("causes", ec, gc)
  end
  initial forever #25 clk = ~clk;
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4000) @(posedge clk);
    finish_test();
  end
  task automatic finish_test();
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
